// file: verilog/via_regs.vh
// Constants for the vectored interrupt acceptance block.
// Assumes inclusion by its bare name from the design files.
`ifndef VIA_REGS_VH
`define VIA_REGS_VH

// ****************************************************************
// Register byte offsets (AXI4-Lite word aligned)
// ****************************************************************
`define VIA_OFF_PSW 8'h00
`define VIA_OFF_REQ 8'h04
`define VIA_OFF_MASK 8'h08
`define VIA_OFF_URG 8'h0C
`define VIA_OFF_STAT 8'h10
`define VIA_OFF_VECTAB 8'h40

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define VIA_PSW_IE 7
`define VIA_PSW_ISP 1
`define VIA_PSW_RST 8'h02
`define VIA_URG_RST 8'hFF
`define VIA_TRAP_VEC_LO 16'h003E
`define VIA_TRAP_VEC_HI 16'h003F

// ****************************************************************
// Sequencer operation codes
// ****************************************************************
`define VIA_OP_NONE 4'h0
`define VIA_OP_EI 4'h1
`define VIA_OP_DI 4'h2
`define VIA_OP_TRAP 4'h3
`define VIA_OP_RETURN_FROM_VECTORED_OP 4'h4
`define VIA_OP_RETURN_FROM_SOFT_TRAP_OP 4'h5
`define VIA_OP_PUSHPSW 4'h6
`define VIA_OP_POPPSW 4'h7
`define VIA_OP_HOLD 4'h8

// ****************************************************************
// Timing, in CPU clocks at 125 MHz
// ****************************************************************
`define VIA_LAT_MIN_HI 7
`define VIA_LAT_MIN_LO 8
`define VIA_LAT_MAX_HI 32
`define VIA_LAT_MAX_LO 33

`endif

// file: verilog/via_vec_mem.v
// Vector table memory: one 16-bit vector per request source.
// Assumes single write port from the bus slave and registered read.
`timescale 1ns/1ps
module via_vec_mem #(
   parameter AW = 3
) (
   // Clock
   input wire clock,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [15:0] wr_data,
   // Read port
   input wire [AW-1:0] rd_addr,
   output reg [15:0] rd_data
);
   reg [15:0] mem [0:(1<<AW)-1];

   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// file: verilog/via_ctrl.v
// Vectored interrupt acceptance logic with AXI4-Lite register access.
// Assumes the instruction sequencer reports instruction boundaries and ops.
`timescale 1ns/1ps
`include "via_regs.vh"

// Notes on behaviour
// - Reset loads status word with 02H.
// - Acceptable means request set, mask clear.
// - Vectored acceptance needs enable flag set.
// - High handler active refuses low requests.
// - Latency 7-32 or 8-33 clocks.
// - Divide may stretch latency past maximum.
// - High level first, then default order.
// - Pending requests kept until acceptable.
// - Accept pushes status, PC; updates flags, vector.
// - Vectored return restores PC then status.
// - Status word byte/bit access; enable/block ops.
// - Save pushes status; restores reload it.
// - Software trap always taken, never masked.
// - Trap stacks, clears enable, vector 003EH.
// - Trap handlers return with trap return.
// - Enabled equal-or-higher priority requests nest.
// - Refused requests wait one main instruction.
// - Nesting follows the acceptance table.
// - In-service flag 0 means high handler.
// - Urgency flag 0 high, 1 low.
// - Priority flags reset to FFH.
// - Flag-touching instructions defer next acceptance.
// - Request during trap not accepted then.
module via_ctrl #(
   parameter NSRC = 8,
   parameter IW = 3
) (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Peripheral request pulses
   input wire [NSRC-1:0] req_set,
   // Sequencer interface
   input wire instr_done,
   input wire [3:0] instr_op,
   input wire [15:0] pc_in,
   input wire [7:0] stack_psw,
   input wire stack_ack,
   input wire psw_wr,
   input wire [7:0] psw_wr_data,
   output reg take_int,
   output reg take_trap,
   output reg [IW-1:0] take_index,
   output reg save_status_op_req,
   output reg [7:0] save_status_op_data,
   output reg push_pc_req,
   output reg [15:0] push_pc_data,
   output reg pc_load,
   output reg [15:0] pc_load_addr,
   output reg [7:0] psw_out,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_IDLE = 3'd0;
   localparam ST_PUSHPSW = 3'd1;
   localparam ST_PUSHPC = 3'd2;
   localparam ST_VEC = 3'd3;
   localparam ST_LOAD = 3'd4;

   reg [7:0] psw_reg;
   reg [NSRC-1:0] req_reg;
   reg [NSRC-1:0] mask_reg;
   reg [NSRC-1:0] urg_reg;
   reg [2:0] st_reg;
   reg hold_reg;
   reg trap_reg;
   reg [7:0] psw_save_reg;
   reg [15:0] pc_save_reg;
   reg [IW-1:0] idx_reg;
   reg [NSRC-1:0] acc;
   reg [NSRC-1:0] cand;
   reg found;
   reg [IW-1:0] win;
   reg win_urg;
   reg bus_hold;
   integer i;

   // ****************************************************************
   // Functions
   // ****************************************************************
   function [IW-1:0] first_set;
      input [NSRC-1:0] v;
      integer k;
      begin
         first_set = {IW{1'b0}};
         for (k = NSRC-1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_set = k[IW-1:0];
            end
         end
      end
   endfunction

   function is_flag_reg;
      input [7:0] a;
      begin
         is_flag_reg = (a == `VIA_OFF_PSW) || (a == `VIA_OFF_REQ) ||
            (a == `VIA_OFF_MASK) || (a == `VIA_OFF_URG);
      end
   endfunction

   // ****************************************************************
   // Acceptance decision
   // ****************************************************************
   always @* begin
      acc = req_reg & ~mask_reg;
      if (!psw_reg[`VIA_PSW_ISP]) begin
         acc = acc & ~urg_reg;
      end
      cand = ((acc & ~urg_reg) != {NSRC{1'b0}}) ? (acc & ~urg_reg) : acc;
      found = (cand != {NSRC{1'b0}});
      win = first_set(cand);
      win_urg = urg_reg[win];
   end

   // ****************************************************************
   // Vector memory
   // ****************************************************************
   // Writes land at the edge where the address and data handshakes complete
   wire bus_wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
   wire bus_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire vec_wr = bus_wr && (s_axi_awaddr[7:6] == 2'b01) && s_axi_wstrb[0];
   wire [15:0] vec_data;

   via_vec_mem #(
      .AW(IW)
   ) u_vec (
      .clock(clock),
      .wr_en(vec_wr),
      .wr_addr(s_axi_awaddr[IW+1:2]),
      .wr_data(s_axi_wdata[15:0]),
      .rd_addr(idx_reg),
      .rd_data(vec_data)
   );

   wire trap_op = instr_done && (instr_op == `VIA_OP_TRAP);
   wire dfr_op = (instr_op == `VIA_OP_EI) || (instr_op == `VIA_OP_DI) ||
      (instr_op == `VIA_OP_RETURN_FROM_VECTORED_OP) || (instr_op == `VIA_OP_RETURN_FROM_SOFT_TRAP_OP) ||
      (instr_op == `VIA_OP_PUSHPSW) || (instr_op == `VIA_OP_POPPSW) ||
      (instr_op == `VIA_OP_HOLD) || psw_wr;
   // The deferring op itself is refused; the next boundary may accept
   wire may_take = instr_done && !bus_hold && !dfr_op &&
      psw_reg[`VIA_PSW_IE] && found && (st_reg == ST_IDLE);

   // ****************************************************************
   // Acceptance sequencer and flags
   // ****************************************************************
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         psw_reg <= `VIA_PSW_RST;
         req_reg <= {NSRC{1'b0}};
         mask_reg <= {NSRC{1'b1}};
         urg_reg <= {NSRC{1'b1}};
         st_reg <= ST_IDLE;
         hold_reg <= 1'b0;
         trap_reg <= 1'b0;
         psw_save_reg <= 8'h00;
         pc_save_reg <= 16'h0000;
         idx_reg <= {IW{1'b0}};
         take_int <= 1'b0;
         take_trap <= 1'b0;
         take_index <= {IW{1'b0}};
         save_status_op_req <= 1'b0;
         save_status_op_data <= 8'h00;
         push_pc_req <= 1'b0;
         push_pc_data <= 16'h0000;
         pc_load <= 1'b0;
         pc_load_addr <= 16'h0000;
         psw_out <= `VIA_PSW_RST;
         bus_hold <= 1'b0;
      end else begin
         take_int <= 1'b0;
         take_trap <= 1'b0;
         pc_load <= 1'b0;
         bus_hold <= bus_hold && !instr_done;
         if (instr_done) begin
            hold_reg <= dfr_op;
         end
         if (bus_wr && is_flag_reg(s_axi_awaddr)) begin
            bus_hold <= 1'b1;
         end
         // Sequencer-driven status word changes
         if (instr_done && st_reg == ST_IDLE) begin
            case (instr_op)
               `VIA_OP_EI: psw_reg[`VIA_PSW_IE] <= 1'b1;
               `VIA_OP_DI: psw_reg[`VIA_PSW_IE] <= 1'b0;
               `VIA_OP_RETURN_FROM_VECTORED_OP, `VIA_OP_RETURN_FROM_SOFT_TRAP_OP, `VIA_OP_POPPSW: begin
                  psw_reg <= stack_psw;
               end
               `VIA_OP_PUSHPSW: begin
                  save_status_op_req <= 1'b1;
                  save_status_op_data <= psw_reg;
               end
               default: begin
               end
            endcase
         end
         if (psw_wr) begin
            psw_reg <= psw_wr_data;
         end
         if (bus_wr && s_axi_awaddr == `VIA_OFF_PSW && s_axi_wstrb[0]) begin
            psw_reg <= s_axi_wdata[7:0];
         end
         if (bus_wr && s_axi_awaddr == `VIA_OFF_MASK && s_axi_wstrb[0]) begin
            mask_reg <= s_axi_wdata[NSRC-1:0];
         end
         if (bus_wr && s_axi_awaddr == `VIA_OFF_URG && s_axi_wstrb[0]) begin
            urg_reg <= s_axi_wdata[NSRC-1:0];
         end
         // Request flags: new requests win over clears
         for (i = 0; i < NSRC; i = i + 1) begin
            if (req_set[i]) begin
               req_reg[i] <= 1'b1;
            end else if (bus_wr && s_axi_awaddr == `VIA_OFF_REQ && s_axi_wstrb[0]) begin
               req_reg[i] <= s_axi_wdata[i];
            end
         end
         case (st_reg)
            ST_IDLE: begin
               if (trap_op) begin
                  trap_reg <= 1'b1;
                  psw_save_reg <= psw_reg;
                  pc_save_reg <= pc_in;
                  psw_reg[`VIA_PSW_IE] <= 1'b0;
                  take_trap <= 1'b1;
                  save_status_op_req <= 1'b1;
                  save_status_op_data <= psw_reg;
                  st_reg <= ST_PUSHPSW;
               end else if (may_take) begin
                  trap_reg <= 1'b0;
                  idx_reg <= win;
                  take_index <= win;
                  take_int <= 1'b1;
                  req_reg[win] <= req_set[win];
                  psw_save_reg <= psw_reg;
                  pc_save_reg <= pc_in;
                  psw_reg[`VIA_PSW_IE] <= 1'b0;
                  psw_reg[`VIA_PSW_ISP] <= win_urg;
                  save_status_op_req <= 1'b1;
                  save_status_op_data <= psw_reg;
                  st_reg <= ST_PUSHPSW;
               end else if (stack_ack) begin
                  save_status_op_req <= 1'b0;
               end
            end
            ST_PUSHPSW: begin
               if (stack_ack) begin
                  save_status_op_req <= 1'b0;
                  push_pc_req <= 1'b1;
                  push_pc_data <= pc_save_reg;
                  st_reg <= ST_PUSHPC;
               end
            end
            ST_PUSHPC: begin
               if (stack_ack) begin
                  push_pc_req <= 1'b0;
                  st_reg <= ST_VEC;
               end
            end
            ST_VEC: begin
               st_reg <= ST_LOAD;
            end
            ST_LOAD: begin
               pc_load <= 1'b1;
               pc_load_addr <= trap_reg ? `VIA_TRAP_VEC_LO : vec_data;
               st_reg <= ST_IDLE;
            end
            default: begin
               st_reg <= ST_IDLE;
            end
         endcase
         psw_out <= psw_reg;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         if (bus_take) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end else if (bus_wr) begin
            // Response only after both handshakes
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_flag_reg(s_axi_awaddr) ||
               s_axi_awaddr[7:6] == 2'b01) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end else if (s_axi_arvalid && s_axi_arready) begin
            // Data only after the address handshake
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `VIA_OFF_PSW: s_axi_rdata <= {24'h00_0000, psw_reg};
               `VIA_OFF_REQ: s_axi_rdata <= {{(32-NSRC){1'b0}}, req_reg};
               `VIA_OFF_MASK: s_axi_rdata <= {{(32-NSRC){1'b0}}, mask_reg};
               `VIA_OFF_URG: s_axi_rdata <= {{(32-NSRC){1'b0}}, urg_reg};
               `VIA_OFF_STAT: s_axi_rdata <= {24'h00_0000, trap_reg, hold_reg,
                  st_reg, idx_reg};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: verif/via_checker.sv
// Checker for the vectored interrupt acceptance block.
// Assumes it is bound to via_ctrl and sees only its ports.
`timescale 1ns/1ps
module via_checker (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Sequencer inputs
   input wire instr_done,
   input wire [3:0] instr_op,
   input wire stack_ack,
   // Entry outputs
   input wire take_int,
   input wire take_trap,
   input wire save_status_op_req,
   input wire [7:0] save_status_op_data,
   input wire push_pc_req,
   input wire pc_load,
   // Status word
   input wire [7:0] psw_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Every op except none and trap defers the next acceptance
   wire hold_op = instr_op != 4'h0 && instr_op != 4'h3;
   // Marks an entry sequence, so a plain status save is not taken for one
   reg entry_reg;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         entry_reg <= 1'b0;
      end else if (take_int | take_trap) begin
         entry_reg <= 1'b1;
      end else if (pc_load) begin
         entry_reg <= 1'b0;
      end
   end
   rst_psw_a: assert property (!$past(nrst) |-> psw_out == 8'h02)
      else $error("status word not at reset value");
   take_stack_a: assert property (
      (take_int | take_trap) |-> save_status_op_req && !push_pc_req)
      else $error("entry did not start with status push");
   hold_op_a: assert property (instr_done && hold_op |=> !take_int)
      else $error("acceptance right after a deferring op");
   psw_wait_a: assert property (
      save_status_op_req && !stack_ack |=> save_status_op_req && $stable(save_status_op_data))
      else $error("status push dropped early");
   pc_after_a: assert property (
      entry_reg && save_status_op_req && stack_ack |-> ##[1:2] push_pc_req)
      else $error("no counter push after status push");
   load_after_a: assert property (push_pc_req && stack_ack |-> ##[1:3] pc_load)
      else $error("no vector load after counter push");
   ie_clear_a: assert property (
      (take_int | take_trap) |-> ##[1:4] !psw_out[7])
      else $error("enable flag kept on entry");
   ei_set_a: assert property (instr_done && instr_op == 4'h1 |-> ##[1:3] psw_out[7])
      else $error("enable op did not set flag");
   di_clr_a: assert property (instr_done && instr_op == 4'h2 |-> ##[1:3] !psw_out[7])
      else $error("block op did not clear flag");
endmodule

bind via_ctrl via_checker u_chk (.clock, .nrst, .instr_done, .instr_op, .stack_ack,
   .take_int, .take_trap, .save_status_op_req, .save_status_op_data, .push_pc_req, .pc_load, .psw_out);

// file: verif/via_stack_model.sv
// Stack port of the instruction sequencer: acknowledges pushes after a delay.
// Assumes one push request at a time, held until acknowledged.
`timescale 1ns/1ps
module via_stack_model (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Cycles to wait before each acknowledge
   input wire [3:0] ack_dly,
   // Push requests
   input wire save_status_op_req,
   input wire [7:0] save_status_op_data,
   input wire push_pc_req,
   input wire [15:0] push_pc_data,
   // Acknowledge and last pushed values
   output reg stack_ack,
   output reg [7:0] got_psw,
   output reg [15:0] got_pc
);
   reg [3:0] wait_reg;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stack_ack <= 1'b0;
         wait_reg <= 4'h0;
         got_psw <= 8'h00;
         got_pc <= 16'h0000;
      end else if (stack_ack | !(save_status_op_req | push_pc_req)) begin
         stack_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (wait_reg < ack_dly) begin
         wait_reg <= wait_reg + 4'h1;
      end else begin
         stack_ack <= 1'b1;
         if (save_status_op_req)
            got_psw <= save_status_op_data;
         else
            got_pc <= push_pc_data;
      end
   end
endmodule

// file: verif/test_vectored_interrupt_acceptance.sv
// Bench for via_ctrl: bus and sequencer drivers, queued result checks.
// Assumes via_ctrl, via_stack_model and via_checker are compiled first.
`timescale 1ns/1ps
module test_vectored_interrupt_acceptance;
   reg clock = 1'b0;
   reg nrst = 1'b0;
   reg instr_done = 1'b0;
   reg [7:0] req_set = 8'h00;
   reg [3:0] instr_op = 4'h0;
   reg [3:0] ack_dly = 4'h0;
   reg [15:0] pc_in = 16'h0000;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0000_0000;
   reg [3:0] s_axi_wstrb = 4'h0;
   wire stack_ack, take_int, take_trap, save_status_op_req, push_pc_req, pc_load;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [7:0] save_status_op_data, psw_out, got_psw;
   wire [15:0] push_pc_data, pc_load_addr, got_pc;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [2:0] take_index;
   reg [7:0] tag_seen = 8'h00;
   wire [31:0] s_axi_rdata;
   reg [63:0] expq[$];
   reg [15:0] seed = 16'h0039;
   reg [15:0] vec[0:7];
   integer err_count = 0, compares = 0, n;
   always #4 clock = ~clock;
   via_ctrl DUT (.clock, .nrst, .req_set, .instr_done, .instr_op, .pc_in, .stack_psw(8'h82),
      .stack_ack, .psw_wr(1'b0), .psw_wr_data(8'h00), .take_int, .take_trap, .take_index,
      .save_status_op_req, .save_status_op_data, .push_pc_req, .push_pc_data, .pc_load, .pc_load_addr,
      .psw_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   via_stack_model u_stack (.clock, .nrst, .ack_dly, .save_status_op_req, .save_status_op_data,
      .push_pc_req, .push_pc_data, .stack_ack, .got_psw, .got_pc);
   function [15:0] lfsr();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      lfsr = seed;
   endfunction
   function [63:0] rx(input [1:0] r, input [31:0] d);
      rx = {6'h00, r, 24'h00_0000, d};
   endfunction
   task final_report;
      begin
         if (expq.size() != 0) begin
            err_count = err_count + 1;
            $display("wrong value queue expected 0 seen %0d", expq.size());
         end
         $display("compares %0d err_count %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task timeout;
      begin
         err_count = err_count + 1;
         $display("wrong value wait expected answer seen none");
         final_report;
      end
   endtask
   task chk(input [63:0] got);
      reg [63:0] e;
      begin
         compares = compares + 1;
         e = expq.size() ? expq.pop_front() : {64{1'bx}};
         if (got !== e) begin
            err_count = err_count + 1;
            $display("wrong value result expected %h seen %h", e, got);
         end
      end
   endtask
   // Oldest note is compared with each result as it appears
   always @(posedge clock) begin
      if (take_int)
         tag_seen <= {5'h00, take_index};
      if (take_trap)
         tag_seen <= 8'hff;
      if (pc_load)
         chk({tag_seen, got_psw, got_pc, 16'h0000, pc_load_addr});
      if (s_axi_rvalid && s_axi_rready)
         chk(rx(s_axi_rresp, s_axi_rdata));
      if (s_axi_bvalid && s_axi_bready)
         chk(rx(s_axi_bresp, 32'h0000_0000));
   end
   task bus(input w, input [7:0] a, input [31:0] d, input [63:0] e);
      integer i;
      reg ok;
      begin
         expq.push_back(e);
         s_axi_awaddr <= a;
         s_axi_araddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= 4'hf;
         s_axi_awvalid <= w;
         s_axi_wvalid <= w;
         s_axi_bready <= w;
         s_axi_arvalid <= !w;
         s_axi_rready <= !w;
         ok = 1'b0;
         for (i = 0; i < 50 && !ok; i = i + 1) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            ok = s_axi_bvalid | s_axi_rvalid;
         end
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
         if (!ok) timeout;
         @(posedge clock);
      end
   endtask
   task req(input [7:0] m);
      begin
         req_set <= m;
         @(posedge clock);
         req_set <= 8'h00;
         @(posedge clock);
      end
   endtask
   // Boundary with op; a nonzero ps means an entry with pushed status ps
   task step(input [3:0] op, input [15:0] va, input [7:0] ps);
      integer i, j;
      reg [7:0] tg;
      begin
         pc_in <= lfsr();
         ack_dly <= {1'b0, seed[2:0]};
         instr_done <= 1'b1;
         instr_op <= op;
         @(posedge clock);
         instr_done <= 1'b0;
         instr_op <= 4'h0;
         // Expected index: the source whose vector is va, or all ones for a trap
         tg = 8'hff;
         for (j = 0; j < 8; j = j + 1)
            if (op != 4'h3 && vec[j] == va) tg = j[7:0];
         if (ps != 8'h00) expq.push_back({tg, ps, pc_in, 16'h0000, va});
         for (i = 0; i < 60 && !pc_load && (ps != 8'h00 || i < 8); i = i + 1)
            @(posedge clock);
         if (ps != 8'h00 && !pc_load) timeout;
         repeat (2) @(posedge clock);
      end
   endtask
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      bus(1'b0, 8'h00, 32'h0000_0000, rx(2'b00, 32'h0000_0002));
      bus(1'b0, 8'h0c, 32'h0000_0000, rx(2'b00, 32'h0000_00ff));
      bus(1'b0, 8'h20, 32'h0000_0000, rx(2'b10, 32'h0000_0000));
      bus(1'b1, 8'h24, 32'h0000_0000, rx(2'b10, 32'h0000_0000));
      for (n = 0; n < 8; n = n + 1) begin
         vec[n] = lfsr();
         bus(1'b1, 8'h40 + {n[5:0], 2'b00}, {16'h0000, vec[n]}, rx(2'b00, 32'h0000_0000));
      end
      $display("test registers done");
      bus(1'b1, 8'h08, 32'h0000_0000, rx(2'b00, 32'h0000_0000));
      bus(1'b1, 8'h0c, 32'h0000_00f7, rx(2'b00, 32'h0000_0000));
      req(8'h28);
      step(4'h0, 16'h0000, 8'h00);
      step(4'h1, 16'h0000, 8'h00);
      step(4'h0, vec[3], 8'h82);
      bus(1'b0, 8'h00, 32'h0000_0000, rx(2'b00, 32'h0000_0000));
      step(4'h1, 16'h0000, 8'h00);
      step(4'h0, 16'h0000, 8'h00);
      step(4'h4, 16'h0000, 8'h00);
      bus(1'b0, 8'h00, 32'h0000_0000, rx(2'b00, 32'h0000_0082));
      step(4'h0, vec[5], 8'h82);
      bus(1'b0, 8'h00, 32'h0000_0000, rx(2'b00, 32'h0000_0002));
      $display("test priority done");
      step(4'h3, 16'h003e, 8'h02);
      step(4'h5, 16'h0000, 8'h00);
      bus(1'b1, 8'h08, 32'h0000_0001, rx(2'b00, 32'h0000_0000));
      step(4'h0, 16'h0000, 8'h00);
      req(8'h07);
      step(4'h0, vec[1], 8'h82);
      step(4'h1, 16'h0000, 8'h00);
      step(4'h0, vec[2], 8'h82);
      step(4'h4, 16'h0000, 8'h00);
      step(4'h4, 16'h0000, 8'h00);
      bus(1'b1, 8'h08, 32'h0000_0000, rx(2'b00, 32'h0000_0000));
      step(4'h2, 16'h0000, 8'h00);
      step(4'h0, 16'h0000, 8'h00);
      step(4'h1, 16'h0000, 8'h00);
      step(4'h6, 16'h0000, 8'h00);
      step(4'h7, 16'h0000, 8'h00);
      step(4'h8, 16'h0000, 8'h00);
      step(4'h0, vec[0], 8'h82);
      $display("test nesting done");
      repeat (10) @(posedge clock);
      final_report;
   end
endmodule
